// ---- src/pwm_pkg.sv ----
package pwm_pkg;
  localparam int unsigned DATA_W = 16;

  // Register byte addresses on the APB slave.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CH3_COUNTER = 8'h08;
  localparam logic [7:0] ADDR_CH4_COUNTER = 8'h0c;
  localparam logic [7:0] ADDR_CH3_LIMIT = 8'h10;
  localparam logic [7:0] ADDR_PAIR1_TR = 8'h14;
  localparam logic [7:0] ADDR_PAIR2_TR = 8'h18;
  localparam logic [7:0] ADDR_PAIR3_TR = 8'h1c;
  localparam logic [7:0] ADDR_PAIR1_BUF = 8'h20;
  localparam logic [7:0] ADDR_PAIR2_BUF = 8'h24;
  localparam logic [7:0] ADDR_PAIR3_BUF = 8'h28;
  localparam logic [7:0] ADDR_CH2_COUNTER = 8'h2c;
  localparam logic [7:0] ADDR_CH2_GEN_A = 8'h30;
  localparam logic [7:0] ADDR_CH2_GEN_B = 8'h34;

  // Control register fields.
  localparam int unsigned CTRL_CMPL_EN = 0;
  localparam int unsigned CTRL_BUF_EN = 1;
  localparam int unsigned CTRL_LEVEL3 = 2;
  localparam int unsigned CTRL_LEVEL4 = 3;
  localparam int unsigned CTRL_PHASE_EN = 4;
  localparam int unsigned CTRL_PHASE_CH = 5;
  localparam int unsigned CTRL_CH2_CLR_A = 7;
  localparam int unsigned CTRL_CH2_CLR_B = 8;
  localparam int unsigned CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h00c;

  // Status register fields; software clears a bit by writing 1 to it.
  localparam int unsigned ST_CH3_MATCH_A = 0;
  localparam int unsigned ST_CH4_OVF = 1;
  localparam int unsigned ST_CH2_MATCH_A = 2;
  localparam int unsigned ST_CH2_MATCH_B = 3;
  localparam int unsigned ST_CH2_OVF = 4;
  localparam int unsigned ST_W = 5;

  localparam logic [DATA_W-1:0] COUNTER_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] LIMIT_RESET = 16'hffff;
  localparam logic [DATA_W-1:0] ZERO16 = 16'h0000;
  localparam logic [DATA_W-1:0] MAX16 = 16'hffff;
  localparam logic [DATA_W-1:0] ONE16 = 16'h0001;
  localparam logic [1:0] PHASE_CHANNEL = 2'h2;
endpackage : pwm_pkg

// ---- src/pair_output.sv ----
`timescale 1ns/10ps
`default_nettype none
// One complementary output pair with a gap between its two active phases.
module pair_output
  import pwm_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  input wire logic down_i,
  input wire logic match_lead_i,
  input wire logic match_lag_i,
  input wire logic active_high_i,
  output logic out_o,
  output logic out_n_o
);
  logic drive_q;
  logic drive_n_q;
  logic drive;
  logic drive_n;

  // The leading counter switches the waveform and the lagging one its complement, so both rest for the margin.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drive_q <= 1'b1;
    end else if (!enable_i) begin
      drive_q <= 1'b1;
    end else if (match_lead_i) begin
      drive_q <= down_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drive_n_q <= 1'b0;
    end else if (!enable_i) begin
      drive_n_q <= 1'b0;
    end else if (match_lag_i) begin
      drive_n_q <= !down_i;
    end
  end

  // A pin is active only while its partner is off, so even a bad setting cannot overlap them.
  assign drive = drive_q && !drive_n_q;
  assign drive_n = drive_n_q && !drive_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_o <= 1'b0;
      out_n_o <= 1'b0;
    end else if (!enable_i) begin
      out_o <= ~active_high_i;
      out_n_o <= ~active_high_i;
    end else begin
      out_o <= drive ~^ active_high_i;
      out_n_o <= drive_n ~^ active_high_i;
    end
  end
endmodule : pair_output
`default_nettype wire

// ---- src/complementary_pwm_phase_counter.sv ----
`timescale 1ns/10ps
`default_nettype none
module complementary_pwm_phase_counter
  import pwm_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic resetn_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Quadrature inputs, synchronous to the clock.
  input wire logic quad_in_a_i,
  input wire logic quad_in_b_i,
  // Complementary pair outputs.
  output logic pair1_out_o,
  output logic pair1_out_n_o,
  output logic pair2_out_o,
  output logic pair2_out_n_o,
  output logic pair3_out_o,
  output logic pair3_out_n_o,
  // Status levels.
  output logic match_a_flag_o,
  output logic overflow_flag_o
);
  logic [CTRL_W-1:0] ctrl_q;
  logic [ST_W-1:0] status_q;
  logic [DATA_W-1:0] ch3_counter_q;
  logic [DATA_W-1:0] ch4_counter_q;
  logic [DATA_W-1:0] ch3_limit_reg_q;
  logic [DATA_W-1:0] pair1_transition_reg_q;
  logic [DATA_W-1:0] pair2_transition_reg_q;
  logic [DATA_W-1:0] pair3_transition_reg_q;
  logic [DATA_W-1:0] pair1_buf_q;
  logic [DATA_W-1:0] pair2_buf_q;
  logic [DATA_W-1:0] pair3_buf_q;
  logic [DATA_W-1:0] ch2_counter_q;
  logic [DATA_W-1:0] ch2_general_a_q;
  logic [DATA_W-1:0] ch2_general_b_q;
  logic down_q;
  logic quad_a_q;
  logic quad_b_q;

  logic cmpl_en;
  logic buf_en;
  logic phase_en;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic limit_match;
  logic ch4_underflow;
  logic up_turn;
  logic pair1_lead;
  logic pair1_lag;
  logic pair2_lead;
  logic pair2_lag;
  logic pair3_lead;
  logic pair3_lag;
  logic quad_up;
  logic quad_down;
  logic ch2_match_a;
  logic ch2_match_b;
  logic ch2_wrap;
  logic [DATA_W-1:0] wdata16;

  assign cmpl_en = ctrl_q[CTRL_CMPL_EN];
  assign buf_en = ctrl_q[CTRL_BUF_EN];
  // Phase counting only takes effect when channel two is the selected channel.
  assign phase_en = ctrl_q[CTRL_PHASE_EN] && (ctrl_q[CTRL_PHASE_CH+1:CTRL_PHASE_CH] == PHASE_CHANNEL);
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !pwrite_i;
  assign wdata16 = pwdata_i[DATA_W-1:0];

  // A match is the last cycle on the matching value, i.e. when the counter moves on.
  assign limit_match = cmpl_en && !down_q && (ch3_counter_q == ch3_limit_reg_q);
  assign ch4_underflow = cmpl_en && down_q && (ch4_counter_q == ZERO16);
  assign up_turn = limit_match;
  // Counting up, counter three meets each transition point first and counter four the margin later; counting down the order reverses.
  assign pair1_lead = cmpl_en && (ch3_counter_q == pair1_transition_reg_q);
  assign pair1_lag = cmpl_en && (ch4_counter_q == pair1_transition_reg_q);
  assign pair2_lead = cmpl_en && (ch3_counter_q == pair2_transition_reg_q);
  assign pair2_lag = cmpl_en && (ch4_counter_q == pair2_transition_reg_q);
  assign pair3_lead = cmpl_en && (ch3_counter_q == pair3_transition_reg_q);
  assign pair3_lag = cmpl_en && (ch4_counter_q == pair3_transition_reg_q);

  // Quadrature decode from registered levels; the inputs are already synchronous.
  assign quad_up = phase_en && (
      (quad_in_b_i && !quad_b_q && !quad_in_a_i) ||
      (quad_in_a_i && !quad_a_q && quad_in_b_i) ||
      (!quad_in_b_i && quad_b_q && quad_in_a_i) ||
      (!quad_in_a_i && quad_a_q && !quad_in_b_i));
  assign quad_down = phase_en && (
      (quad_in_b_i && !quad_b_q && quad_in_a_i) ||
      (quad_in_a_i && !quad_a_q && !quad_in_b_i) ||
      (!quad_in_b_i && quad_b_q && !quad_in_a_i) ||
      (!quad_in_a_i && quad_a_q && quad_in_b_i));
  assign ch2_match_a = (quad_up || quad_down) && (ch2_counter_q == ch2_general_a_q);
  assign ch2_match_b = (quad_up || quad_down) && (ch2_counter_q == ch2_general_b_q);
  assign ch2_wrap = (quad_up && ch2_counter_q == MAX16) || (quad_down && ch2_counter_q == ZERO16);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      quad_a_q <= 1'b0;
      quad_b_q <= 1'b0;
    end else begin
      quad_a_q <= quad_in_a_i;
      quad_b_q <= quad_in_b_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_en && paddr_i == ADDR_CTRL) begin
      ctrl_q <= pwdata_i[CTRL_W-1:0];
    end
  end

  // Direction is shared by both counters.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      down_q <= 1'b0;
    end else if (!cmpl_en) begin
      down_q <= 1'b0;
    end else if (limit_match) begin
      down_q <= 1'b1;
    end else if (ch4_underflow) begin
      down_q <= 1'b0;
    end
  end

  // Counter three runs past the limit by one and counter four below zero by one at the turns, then they come back.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ch3_counter_q <= COUNTER_RESET;
      ch4_counter_q <= COUNTER_RESET;
    end else if (wr_en && paddr_i == ADDR_CH3_COUNTER) begin
      ch3_counter_q <= wdata16;
    end else if (wr_en && paddr_i == ADDR_CH4_COUNTER) begin
      ch4_counter_q <= wdata16;
    end else if (cmpl_en) begin
      if (!down_q && !limit_match) begin
        ch3_counter_q <= ch3_counter_q + ONE16;
        ch4_counter_q <= ch4_counter_q + ONE16;
      end else if (down_q && !ch4_underflow) begin
        ch3_counter_q <= ch3_counter_q - ONE16;
        ch4_counter_q <= ch4_counter_q - ONE16;
      end else if (limit_match) begin
        ch3_counter_q <= ch3_counter_q + ONE16;
        ch4_counter_q <= ch4_counter_q + ONE16;
      end else begin
        ch3_counter_q <= ch3_counter_q - ONE16;
        ch4_counter_q <= ch4_counter_q - ONE16;
      end
    end
  end

  // Limit and transition registers; buffers reload the transition registers at both turns when enabled.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ch3_limit_reg_q <= LIMIT_RESET;
      pair1_transition_reg_q <= LIMIT_RESET;
      pair2_transition_reg_q <= LIMIT_RESET;
      pair3_transition_reg_q <= LIMIT_RESET;
    end else begin
      if (wr_en && paddr_i == ADDR_CH3_LIMIT) begin
        ch3_limit_reg_q <= wdata16;
      end
      if (buf_en && cmpl_en && (up_turn || ch4_underflow)) begin
        pair1_transition_reg_q <= pair1_buf_q;
        pair2_transition_reg_q <= pair2_buf_q;
        pair3_transition_reg_q <= pair3_buf_q;
      end else if (wr_en && paddr_i == ADDR_PAIR1_TR) begin
        pair1_transition_reg_q <= wdata16;
      end else if (wr_en && paddr_i == ADDR_PAIR2_TR) begin
        pair2_transition_reg_q <= wdata16;
      end else if (wr_en && paddr_i == ADDR_PAIR3_TR) begin
        pair3_transition_reg_q <= wdata16;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pair1_buf_q <= LIMIT_RESET;
      pair2_buf_q <= LIMIT_RESET;
      pair3_buf_q <= LIMIT_RESET;
    end else if (wr_en && paddr_i == ADDR_PAIR1_BUF) begin
      pair1_buf_q <= wdata16;
    end else if (wr_en && paddr_i == ADDR_PAIR2_BUF) begin
      pair2_buf_q <= wdata16;
    end else if (wr_en && paddr_i == ADDR_PAIR3_BUF) begin
      pair3_buf_q <= wdata16;
    end
  end

  // Channel two: quadrature counting with its own compare and clear selection.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ch2_counter_q <= COUNTER_RESET;
    end else if (wr_en && paddr_i == ADDR_CH2_COUNTER) begin
      ch2_counter_q <= wdata16;
    end else if ((ch2_match_a && ctrl_q[CTRL_CH2_CLR_A]) || (ch2_match_b && ctrl_q[CTRL_CH2_CLR_B])) begin
      ch2_counter_q <= ZERO16;
    end else if (quad_up) begin
      ch2_counter_q <= ch2_counter_q + ONE16;
    end else if (quad_down) begin
      ch2_counter_q <= ch2_counter_q - ONE16;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ch2_general_a_q <= LIMIT_RESET;
      ch2_general_b_q <= LIMIT_RESET;
    end else if (wr_en && paddr_i == ADDR_CH2_GEN_A) begin
      ch2_general_a_q <= wdata16;
    end else if (wr_en && paddr_i == ADDR_CH2_GEN_B) begin
      ch2_general_b_q <= wdata16;
    end
  end

  // Sticky flags: a set in the same cycle as a write-one clear wins.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_q <= '0;
    end else begin
      if (wr_en && paddr_i == ADDR_STATUS) begin
        status_q <= status_q & ~pwdata_i[ST_W-1:0];
      end
      if (up_turn) begin
        status_q[ST_CH3_MATCH_A] <= 1'b1;
      end
      if (ch4_underflow) begin
        status_q[ST_CH4_OVF] <= 1'b1;
      end
      if (ch2_match_a) begin
        status_q[ST_CH2_MATCH_A] <= 1'b1;
      end
      if (ch2_match_b) begin
        status_q[ST_CH2_MATCH_B] <= 1'b1;
      end
      if (ch2_wrap) begin
        status_q[ST_CH2_OVF] <= 1'b1;
      end
    end
  end

  // Read mux: no wait states, unmapped addresses answer with an error.
  always_comb begin
    addr_ok = 1'b1;
    prdata_o = '0;
    if (paddr_i == ADDR_CTRL) begin
      prdata_o[CTRL_W-1:0] = ctrl_q;
    end else if (paddr_i == ADDR_STATUS) begin
      prdata_o[ST_W-1:0] = status_q;
    end else if (paddr_i == ADDR_CH3_COUNTER) begin
      prdata_o[DATA_W-1:0] = ch3_counter_q;
    end else if (paddr_i == ADDR_CH4_COUNTER) begin
      prdata_o[DATA_W-1:0] = ch4_counter_q;
    end else if (paddr_i == ADDR_CH3_LIMIT) begin
      prdata_o[DATA_W-1:0] = ch3_limit_reg_q;
    end else if (paddr_i == ADDR_PAIR1_TR) begin
      prdata_o[DATA_W-1:0] = pair1_transition_reg_q;
    end else if (paddr_i == ADDR_PAIR2_TR) begin
      prdata_o[DATA_W-1:0] = pair2_transition_reg_q;
    end else if (paddr_i == ADDR_PAIR3_TR) begin
      prdata_o[DATA_W-1:0] = pair3_transition_reg_q;
    end else if (paddr_i == ADDR_PAIR1_BUF) begin
      prdata_o[DATA_W-1:0] = pair1_buf_q;
    end else if (paddr_i == ADDR_PAIR2_BUF) begin
      prdata_o[DATA_W-1:0] = pair2_buf_q;
    end else if (paddr_i == ADDR_PAIR3_BUF) begin
      prdata_o[DATA_W-1:0] = pair3_buf_q;
    end else if (paddr_i == ADDR_CH2_COUNTER) begin
      prdata_o[DATA_W-1:0] = ch2_counter_q;
    end else if (paddr_i == ADDR_CH2_GEN_A) begin
      prdata_o[DATA_W-1:0] = ch2_general_a_q;
    end else if (paddr_i == ADDR_CH2_GEN_B) begin
      prdata_o[DATA_W-1:0] = ch2_general_b_q;
    end else begin
      addr_ok = 1'b0;
    end
    if (!rd_en) begin
      prdata_o = '0;
    end
  end

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok;
  assign match_a_flag_o = status_q[ST_CH3_MATCH_A];
  assign overflow_flag_o = status_q[ST_CH4_OVF];

  // While the mode is on, all six pins are PWM outputs; level select inverts each channel's pairs.
  pair_output u_pair1 (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .enable_i(cmpl_en),
    .down_i(down_q),
    .match_lead_i(pair1_lead),
    .match_lag_i(pair1_lag),
    .active_high_i(ctrl_q[CTRL_LEVEL3]),
    .out_o(pair1_out_o),
    .out_n_o(pair1_out_n_o)
  );

  pair_output u_pair2 (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .enable_i(cmpl_en),
    .down_i(down_q),
    .match_lead_i(pair2_lead),
    .match_lag_i(pair2_lag),
    .active_high_i(ctrl_q[CTRL_LEVEL4]),
    .out_o(pair2_out_o),
    .out_n_o(pair2_out_n_o)
  );

  pair_output u_pair3 (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .enable_i(cmpl_en),
    .down_i(down_q),
    .match_lead_i(pair3_lead),
    .match_lag_i(pair3_lag),
    .active_high_i(ctrl_q[CTRL_LEVEL4]),
    .out_o(pair3_out_o),
    .out_n_o(pair3_out_n_o)
  );
endmodule : complementary_pwm_phase_counter
`default_nettype wire

// ---- test/pwm_checker_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module pwm_checker
  import pwm_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic resetn_i,
  // Bus.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Pins.
  input wire logic quad_in_a_i,
  input wire logic quad_in_b_i,
  input wire logic pair1_out_o,
  input wire logic pair1_out_n_o,
  input wire logic pair2_out_o,
  input wire logic pair2_out_n_o,
  input wire logic pair3_out_o,
  input wire logic pair3_out_n_o,
  input wire logic match_a_flag_o,
  input wire logic overflow_flag_o
);
  logic [CTRL_W-1:0] ctrl_q;
  logic wr_ctrl;
  logic wr_st;
  logic mapped;
  assign wr_ctrl = psel_i && penable_i && pwrite_i && paddr_i == ADDR_CTRL;
  assign wr_st = psel_i && penable_i && pwrite_i && paddr_i == ADDR_STATUS;
  assign mapped = paddr_i[1:0] == 2'h0 && paddr_i <= ADDR_CH2_GEN_B;
  // Shadow of the control word; pins are judged only once a mode has settled for three edges.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata_i[CTRL_W-1:0];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  a_ready_high: assert property (pready_o) else $error("pready low");
  a_err_unmapped: assert property (pslverr_o == (psel_i && penable_i && !mapped)) else $error("pslverr wrong");
  a_read_idle: assert property (!(psel_i && !pwrite_i) |-> prdata_o == 32'h00000000) else $error("prdata not idle");
  a_read_upper: assert property (prdata_o[31:16] == 16'h0000) else $error("prdata upper bits set");
  a_pair_compl: assert property (($past(ctrl_q) == ctrl_q && $past(ctrl_q, 2) == ctrl_q && ctrl_q[CTRL_CMPL_EN])
    |-> !({pair1_out_o, pair1_out_n_o} == {2{ctrl_q[CTRL_LEVEL3]}})
    && !({pair2_out_o, pair2_out_n_o} == {2{ctrl_q[CTRL_LEVEL4]}})
    && !({pair3_out_o, pair3_out_n_o} == {2{ctrl_q[CTRL_LEVEL4]}}))
    else $error("pair outputs overlap");
  a_pair_idle: assert property (($past(ctrl_q) == ctrl_q && $past(ctrl_q, 2) == ctrl_q && !ctrl_q[CTRL_CMPL_EN])
    |-> {pair1_out_o, pair1_out_n_o} == {2{!ctrl_q[CTRL_LEVEL3]}}
    && {pair2_out_o, pair2_out_n_o, pair3_out_o, pair3_out_n_o} == {4{!ctrl_q[CTRL_LEVEL4]}})
    else $error("idle pair level wrong");
  a_match_clear: assert property ($fell(match_a_flag_o) |-> $past(wr_st && pwdata_i[ST_CH3_MATCH_A]))
    else $error("match flag cleared alone");
  a_ovf_clear: assert property ($fell(overflow_flag_o) |-> $past(wr_st && pwdata_i[ST_CH4_OVF]))
    else $error("overflow flag cleared alone");
  a_match_mode: assert property ($rose(match_a_flag_o) |-> $past(ctrl_q[CTRL_CMPL_EN]))
    else $error("match flag outside mode");
  a_ovf_mode: assert property ($rose(overflow_flag_o) |-> $past(ctrl_q[CTRL_CMPL_EN]))
    else $error("overflow flag outside mode");
  c_match: cover property ($rose(match_a_flag_o));
  c_ovf: cover property ($rose(overflow_flag_o));
  c_err: cover property (pslverr_o);
  c_dead: cover property ($past(ctrl_q[CTRL_CMPL_EN], 2) && pair2_out_o == pair2_out_n_o);
endmodule : pwm_checker
`default_nettype wire

// ---- test/quad_encoder_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Quadrature source: one step per request, each level held at least five cycles.
module quad_encoder_model (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic resetn_i,
  // Step request.
  input wire logic step_i,
  input wire logic dir_up_i,
  output logic ready_o,
  // Encoder lines.
  output logic quad_a_o,
  output logic quad_b_o
);
  logic [1:0] phase_q;
  logic [2:0] hold_q;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_q <= 2'h0;
      hold_q <= 3'h0;
    end else if (step_i && hold_q == 3'h0) begin
      phase_q <= dir_up_i ? phase_q + 2'h1 : phase_q - 2'h1;
      hold_q <= 3'h4;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end
  end
  assign ready_o = hold_q == 3'h0;
  // Gray order 00, 01, 11, 10 as (a, b) when stepping up.
  assign quad_a_o = phase_q[1];
  assign quad_b_o = phase_q[1] ^ phase_q[0];
endmodule : quad_encoder_model
`default_nettype wire

// ---- test/complementary_pwm_phase_counter_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module complementary_pwm_phase_counter_test;
  import pwm_pkg::*;
  logic clock_i, resetn_i, psel, penable, pwrite, pready, pslverr, qa, qb, step, dir_up, q_ready;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic p1, p1n, p2, p2n, p3, p3n, mflag, oflag, pm, po, pp1, pp2, er, v;
  int err_count, compares, cyc, n_match, n_ovf, n_tog1, n_tog2, t_match, t_ovf, tg1, tg2;
  complementary_pwm_phase_counter complementary_pwm_phase_counter_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .quad_in_a_i(qa), .quad_in_b_i(qb), .pair1_out_o(p1),
    .pair1_out_n_o(p1n), .pair2_out_o(p2), .pair2_out_n_o(p2n), .pair3_out_o(p3), .pair3_out_n_o(p3n),
    .match_a_flag_o(mflag), .overflow_flag_o(oflag));
  quad_encoder_model quad_encoder_model_inst (.clock_i(clock_i), .resetn_i(resetn_i), .step_i(step),
    .dir_up_i(dir_up), .ready_o(q_ready), .quad_a_o(qa), .quad_b_o(qb));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Event stamps use pre-edge values, so they never race the design's own updates.
  always @(posedge clock_i) begin
    cyc++;
    if (mflag === 1'b1 && pm !== 1'b1) begin n_match++; t_match = cyc; end
    if (oflag === 1'b1 && po !== 1'b1) begin n_ovf++; t_ovf = cyc; end
    if (p1 !== pp1) n_tog1++;
    if (p2 !== pp2) n_tog2++;
    pm = mflag; po = oflag; pp1 = p1; pp2 = p2;
  end
  task wrap_up;
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task timeout(input string name);
    err_count++;
    $display("wrong value %s expected done seen timeout", name);
    wrap_up();
  endtask : timeout
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clock_i); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout("pready");
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock_i);
  endtask : apb
  task wait_flag(input bit ovf);
    int base, n;
    base = ovf ? n_ovf : n_match;
    n = 0;
    while ((ovf ? n_ovf : n_match) == base && n < 400) begin @(posedge clock_i); n++; end
    if ((ovf ? n_ovf : n_match) == base) timeout("flag");
  endtask : wait_flag
  task qsteps(input logic up, input int cnt);
    int n;
    for (int i = 0; i < cnt; i++) begin
      dir_up <= up; step <= 1'b1;
      @(posedge clock_i);
      step <= 1'b0;
      n = 0;
      do begin @(posedge clock_i); n++; end while (q_ready !== 1'b1 && n < 20);
      if (q_ready !== 1'b1) timeout("encoder");
    end
  endtask : qsteps
  task reset_and_bus;
    apb(1'b0, ADDR_CTRL, 0); check("ctrl reset", {23'h0, CTRL_RESET}, rd);
    apb(1'b0, ADDR_CH3_LIMIT, 0); check("limit reset", {16'h0, LIMIT_RESET}, rd);
    apb(1'b0, ADDR_PAIR1_TR, 0); check("pair1 reset", 32'h0000ffff, rd);
    apb(1'b0, ADDR_CH3_COUNTER, 0); check("ch3 reset", {16'h0, COUNTER_RESET}, rd);
    apb(1'b1, 8'h38, 32'h1); check("unmapped write err", 32'h1, {31'h0, er});
    apb(1'b0, 8'h38, 0); check("unmapped read", 32'h0, rd); check("unmapped err", 32'h1, {31'h0, er});
  endtask : reset_and_bus
  // Margin 2, limit 40: each half period spans limit - margin + 2 edges.
  task comp_run;
    logic [7:0] ad [9];
    logic [15:0] dv [9];
    ad = '{ADDR_CH4_COUNTER, ADDR_CH3_COUNTER, ADDR_CH3_LIMIT, ADDR_PAIR1_TR, ADDR_PAIR2_TR, ADDR_PAIR3_TR,
      ADDR_PAIR1_BUF, ADDR_PAIR2_BUF, ADDR_PAIR3_BUF};
    dv = '{16'h0000, 16'h0002, 16'h0028, 16'h0100, 16'h0010, 16'h0014, 16'h0100, 16'h0010, 16'h0014};
    for (int i = 0; i < 9; i++) apb(1'b1, ad[i], {16'h0, dv[i]});
    apb(1'b1, ADDR_CTRL, 32'h00f);
    wait_flag(1'b0);
    tg1 = n_tog1; tg2 = n_tog2;
    apb(1'b1, ADDR_STATUS, 32'h3);
    wait_flag(1'b1);
    check("limit to underflow", 32'd40, t_ovf - t_match);
    wait_flag(1'b0);
    check("underflow to limit", 32'd40, t_match - t_ovf);
    check("pair2 toggles", 32'd2, n_tog2 - tg2);
    check("pair1 toggles", 32'd0, n_tog1 - tg1);
    v = p1;
    apb(1'b1, ADDR_CTRL, 32'h00b);
    @(posedge clock_i);
    check("level inverted", {31'h0, !v}, {31'h0, p1});
    apb(1'b1, ADDR_CTRL, 32'h00f);
    apb(1'b1, ADDR_STATUS, 32'h3);
    wait_flag(1'b1);
    apb(1'b1, ADDR_STATUS, 32'h3);
    apb(1'b1, ADDR_PAIR1_BUF, 32'h5);
    apb(1'b0, ADDR_PAIR1_TR, 0); check("pair1 before copy", 32'h100, rd);
    wait_flag(1'b0);
    apb(1'b0, ADDR_PAIR1_TR, 0); check("pair1 after copy", 32'h5, rd);
    apb(1'b0, ADDR_STATUS, 0); check("match flag", 32'h1, rd & 32'h1);
  endtask : comp_run
  task quad_run;
    apb(1'b1, ADDR_CTRL, 32'h05c);
    apb(1'b1, ADDR_CH2_COUNTER, 32'h0);
    apb(1'b1, ADDR_CH2_GEN_A, 32'h7);
    qsteps(1'b1, 8);
    apb(1'b0, ADDR_CH2_COUNTER, 0); check("ch2 up", 32'h8, rd);
    apb(1'b0, ADDR_STATUS, 0); check("ch2 match a", 32'h4, rd & 32'h4);
    qsteps(1'b0, 3);
    apb(1'b0, ADDR_CH2_COUNTER, 0); check("ch2 down", 32'h5, rd);
    apb(1'b1, ADDR_CTRL, 32'h03c);
    qsteps(1'b1, 4);
    apb(1'b0, ADDR_CH2_COUNTER, 0); check("wrong channel", 32'h5, rd);
    apb(1'b1, ADDR_CTRL, 32'h0dc);
    qsteps(1'b1, 3);
    apb(1'b0, ADDR_CH2_COUNTER, 0); check("ch2 clear on a", 32'h0, rd);
    qsteps(1'b0, 1);
    apb(1'b0, ADDR_STATUS, 0); check("ch2 wrap", 32'h10, rd & 32'h10);
  endtask : quad_run
  initial begin
    resetn_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    step = 1'b0; dir_up = 1'b1;
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    reset_and_bus();
    comp_run();
    quad_run();
    wrap_up();
  end
endmodule : complementary_pwm_phase_counter_test
bind complementary_pwm_phase_counter pwm_checker pwm_checker_inst (.clock_i(clock_i), .resetn_i(resetn_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .quad_in_a_i(quad_in_a_i),
  .quad_in_b_i(quad_in_b_i), .pair1_out_o(pair1_out_o), .pair1_out_n_o(pair1_out_n_o), .pair2_out_o(pair2_out_o),
  .pair2_out_n_o(pair2_out_n_o), .pair3_out_o(pair3_out_o), .pair3_out_n_o(pair3_out_n_o),
  .match_a_flag_o(match_a_flag_o), .overflow_flag_o(overflow_flag_o));
`default_nettype wire
